// ### common/ast_params.svh
// constants for the async serial transceiver
// assumes a 100 MHz sys_clk and Avalon-MM word addressing
`ifndef AST_PARAMS_SVH
`define AST_PARAMS_SVH
// register word indices
`define AST_IX_FLAGS 3'h0
`define AST_IX_ENAB 3'h1
`define AST_IX_PRIO 3'h2
`define AST_IX_RCSC 3'h3
`define AST_IX_TXBUF 3'h4
`define AST_IX_TXSC 3'h5
`define AST_IX_DIV 3'h6
`define AST_IX_RXBUF 3'h7
// flag, enable and priority bit positions
`define AST_B_RCF 5
`define AST_B_TXF 4
// receive status and control bits
`define AST_B_PEN 7
`define AST_B_RX9 6
`define AST_B_SGL 5
`define AST_B_CRX 4
`define AST_B_ADT 3
`define AST_B_FE 2
`define AST_B_OE 1
`define AST_B_RB9 0
// transmit status and control bits
`define AST_B_CSR 7
`define AST_B_TX9 6
`define AST_B_TXE 5
`define AST_B_SYN 4
`define AST_B_HS 2
`define AST_B_SRE 1
`define AST_B_TB9 0
// writable masks of the control registers
`define AST_M_RCSC 8'hF8
`define AST_M_TXSC 8'hF5
`define AST_M_IRQ 8'h30
// timing: samples per bit, half bit, x64 prescale end
`define AST_T_LAST 4'hF
`define AST_T_HALF 4'h7
`define AST_PRE_END 2'h3
`define AST_NB8 4'h7
`define AST_NB9 4'h8
`endif

// ### common/ast_pkg.sv
// types of the async serial transceiver
// assumes ast_params.svh on the include path
package ast_pkg;
`include "ast_params.svh"
  typedef enum logic [3:0] {TX_IDLE = 4'h1, TX_START = 4'h2, TX_DATA = 4'h4, TX_STOP = 4'h8} ast_tx_t;
  typedef enum logic [3:0] {RX_IDLE = 4'h1, RX_START = 4'h2, RX_DATA = 4'h4, RX_STOP = 4'h8} ast_rx_t;
  typedef struct packed {
    logic waitreq;
    logic [31:0] rdata;
    logic [7:0] enab, prio, rcsc, txsc, div, txbuf, rxbuf;
    logic tx_full, tx_flag, rx_full, rx_b9, fr_err, ov_err;
    logic [7:0] brg_cnt;
    logic [1:0] pre;
    ast_tx_t tx_st;
    logic [3:0] tx_tick, tx_bit;
    logic [8:0] shreg;
    logic txo;
    logic s1, s2, s3, rxf;
    ast_rx_t rx_st;
    logic [3:0] rx_tick, rx_bit;
    logic [8:0] rx_sh;
    logic tx_irq, rx_irq;
  } ast_st_t;
endpackage : ast_pkg

// ### src/ast_top.sv
// async serial transceiver: registers, baud generator, tx, rx
// assumes an Avalon-MM master on sys_clk and a remote station
//
// Our own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
module ast_top #(
  parameter int BRG_W = 8
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic serial_receive_pin,
  output logic serial_transmit_pin,
  output logic tx_int_req,
  output logic rx_int_req
);
  import ast_pkg::*;

  //////////////////////////////////////////////////////////////
  // elaboration check
  // divisor width is fixed by the register map
  if (BRG_W != 8) begin : g_chk
    $error("ast_top: BRG_W must be 8");
  end

  //////////////////////////////////////////////////////////////
  // reset release
  logic [1:0] rst_sync; // two-flop release chain
  logic rst_n; // synchronised reset

  // release after two clean edges
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  //////////////////////////////////////////////////////////////
  // state
  ast_st_t st_reg; // all registered state but the reset chain
  ast_st_t st_next; // its next value

  // readback of one register word
  function automatic logic [31:0] rd_word(input ast_st_t s, input logic [2:0] ix);
    logic [7:0] v;
    v = 8'h00;
    unique case (ix)
      `AST_IX_FLAGS: begin
        v[`AST_B_RCF] = s.rx_full;
        v[`AST_B_TXF] = s.tx_flag;
      end
      `AST_IX_ENAB: v = s.enab;
      `AST_IX_PRIO: v = s.prio;
      `AST_IX_RCSC: v = {s.rcsc[7:3], s.fr_err, s.ov_err, s.rx_b9};
      `AST_IX_TXBUF: v = s.txbuf;
      `AST_IX_TXSC: v = {s.txsc[7:2], s.tx_st == TX_IDLE, s.txsc[0]};
      `AST_IX_DIV: v = s.div;
      `AST_IX_RXBUF: v = s.rxbuf;
    endcase
    return {24'h000000, v};
  endfunction : rd_word

  //////////////////////////////////////////////////////////////
  // decoded controls
  logic active; // port running
  logic tx_en, tx_nine, rx_on, rx_nine, addr_det;
  logic samp; // x16 sample tick
  logic brg_tick; // divisor underflow
  logic acc; // bus access taken this edge
  logic wr_tx; // transmit buffer written
  logic pop_rx; // receive buffer read
  logic load_tx; // buffer to shifter move
  logic rx_done; // stop bit sampled
  logic rx_keep; // word passes the filter
  logic [7:0] rx_d; // assembled character
  logic rx_d9; // assembled ninth bit

  // control decode
  always_comb begin
    active = st_reg.rcsc[`AST_B_PEN] && !st_reg.txsc[`AST_B_SYN];
    tx_en = st_reg.txsc[`AST_B_TXE];
    tx_nine = st_reg.txsc[`AST_B_TX9];
    rx_on = active && st_reg.rcsc[`AST_B_CRX];
    rx_nine = st_reg.rcsc[`AST_B_RX9];
    addr_det = st_reg.rcsc[`AST_B_ADT];
    brg_tick = active && st_reg.brg_cnt == 8'h00;
    // x64 mode divides the generator by four more
    samp = brg_tick && (st_reg.txsc[`AST_B_HS] || st_reg.pre == `AST_PRE_END);
    acc = !st_reg.waitreq && (avs_read || avs_write);
    wr_tx = acc && avs_write && avs_address == `AST_IX_TXBUF;
    pop_rx = acc && avs_read && avs_address == `AST_IX_RXBUF;
    load_tx = active && tx_en && st_reg.tx_full && st_reg.tx_st == TX_IDLE;
    rx_done = samp && st_reg.rx_st == RX_STOP && st_reg.rx_tick == `AST_T_LAST;
    // 8-bit frames leave the byte in the top of the shifter
    rx_d = rx_nine ? st_reg.rx_sh[7:0] : st_reg.rx_sh[8:1];
    rx_d9 = rx_nine ? st_reg.rx_sh[8] : 1'b0;
    rx_keep = !(rx_nine && addr_det && !rx_d9);
  end

  //////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    st_next = st_reg;
    // bus slave: answer one cycle after the request
    st_next.waitreq = !((avs_read || avs_write) && st_reg.waitreq);
    st_next.rdata = rd_word(st_reg, avs_address);
    // register writes; the shifter has no index
    if (acc && avs_write) begin
      unique case (avs_address)
        `AST_IX_ENAB: st_next.enab = avs_writedata[7:0] & `AST_M_IRQ;
        `AST_IX_PRIO: st_next.prio = avs_writedata[7:0] & `AST_M_IRQ;
        `AST_IX_RCSC: st_next.rcsc = avs_writedata[7:0] & `AST_M_RCSC;
        `AST_IX_TXSC: st_next.txsc = avs_writedata[7:0] & `AST_M_TXSC;
        `AST_IX_DIV: st_next.div = avs_writedata[7:0];
        `AST_IX_TXBUF: begin
          st_next.txbuf = avs_writedata[7:0];
          st_next.tx_full = 1'b1;
        end
        default: begin
          // flags and receive buffer ignore writes
        end
      endcase
    end
    // baud generator shared by both directions
    if (!active) begin
      st_next.brg_cnt = st_reg.div;
      st_next.pre = 2'h0;
    end else if (brg_tick) begin
      st_next.brg_cnt = st_reg.div;
      st_next.pre = st_reg.pre + 2'h1;
    end else begin
      st_next.brg_cnt = st_reg.brg_cnt - 8'h01;
    end
    // flag follows the buffer one cycle late, never gated
    st_next.tx_flag = !st_reg.tx_full;

    // transmitter
    unique case (st_reg.tx_st)
      TX_IDLE: begin
        st_next.txo = 1'b1;
        if (load_tx) begin
          // one cycle move, buffer then counts empty unless written in the same edge
          st_next.shreg = {st_reg.txsc[`AST_B_TB9], st_reg.txbuf};
          st_next.tx_full = wr_tx;
          st_next.tx_st = TX_START;
          st_next.tx_tick = 4'h0;
          st_next.txo = 1'b0;
        end
      end
      TX_START: begin
        if (samp) begin
          st_next.tx_tick = st_reg.tx_tick + 4'h1;
          if (st_reg.tx_tick == `AST_T_LAST) begin
            st_next.tx_st = TX_DATA;
            st_next.tx_bit = 4'h0;
            st_next.txo = st_reg.shreg[0];
          end
        end
      end
      TX_DATA: begin
        if (samp) begin
          st_next.tx_tick = st_reg.tx_tick + 4'h1;
          if (st_reg.tx_tick == `AST_T_LAST) begin
            st_next.shreg = {1'b0, st_reg.shreg[8:1]};
            st_next.tx_bit = st_reg.tx_bit + 4'h1;
            st_next.txo = st_reg.shreg[1];
            // ninth bit only in nine-bit mode, no parity made
            if (st_reg.tx_bit == (tx_nine ? `AST_NB9 : `AST_NB8)) begin
              st_next.tx_st = TX_STOP;
              st_next.txo = 1'b1;
            end
          end
        end
      end
      TX_STOP: begin
        if (samp) begin
          st_next.tx_tick = st_reg.tx_tick + 4'h1;
          // reload only once the stop bit is out
          if (st_reg.tx_tick == `AST_T_LAST) begin
            st_next.tx_st = TX_IDLE;
          end
        end
      end
    endcase
    // dropping the enable or the port aborts a frame
    if (!active || !tx_en) begin
      st_next.tx_st = TX_IDLE;
      st_next.txo = 1'b1;
    end

    // pin synchroniser; a change counts when stages two and three agree
    st_next.s1 = serial_receive_pin;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    if (st_reg.s2 == st_reg.s3) begin
      st_next.rxf = st_reg.s3;
    end

    // receiver, x16 oversampling recovery
    unique case (st_reg.rx_st)
      RX_IDLE: begin
        if (samp && !st_reg.rxf) begin
          st_next.rx_st = RX_START;
          st_next.rx_tick = 4'h0;
        end
      end
      RX_START: begin
        if (samp) begin
          st_next.rx_tick = st_reg.rx_tick + 4'h1;
          // mid-bit check rejects glitches
          if (st_reg.rx_tick == `AST_T_HALF) begin
            st_next.rx_st = st_reg.rxf ? RX_IDLE : RX_DATA;
            st_next.rx_tick = 4'h0;
            st_next.rx_bit = 4'h0;
          end
        end
      end
      RX_DATA: begin
        if (samp) begin
          st_next.rx_tick = st_reg.rx_tick + 4'h1;
          // shift at bit rate, first bit ends lowest
          if (st_reg.rx_tick == `AST_T_LAST) begin
            st_next.rx_sh = {st_reg.rxf, st_reg.rx_sh[8:1]};
            st_next.rx_bit = st_reg.rx_bit + 4'h1;
            if (st_reg.rx_bit == (rx_nine ? `AST_NB9 : `AST_NB8)) begin
              st_next.rx_st = RX_STOP;
            end
          end
        end
      end
      RX_STOP: begin
        if (samp) begin
          st_next.rx_tick = st_reg.rx_tick + 4'h1;
          if (st_reg.rx_tick == `AST_T_LAST) begin
            st_next.rx_st = RX_IDLE;
          end
        end
      end
    endcase

    // receive buffer; a read in the same edge frees it first
    if (pop_rx) begin
      st_next.rx_full = 1'b0;
    end
    if (rx_done && rx_keep) begin
      if (st_reg.rx_full && !pop_rx) begin
        st_next.ov_err = 1'b1;
      end else begin
        st_next.rxbuf = rx_d;
        st_next.rx_b9 = rx_d9;
        st_next.fr_err = !st_reg.rxf;
        st_next.rx_full = 1'b1;
      end
    end
    // clearing the enable clears errors and stops reception
    if (!rx_on) begin
      st_next.rx_st = RX_IDLE;
    end
    if (!st_reg.rcsc[`AST_B_CRX]) begin
      st_next.ov_err = 1'b0;
      st_next.fr_err = 1'b0;
    end

    // interrupt requests gated by the enables
    st_next.tx_irq = st_reg.tx_flag && st_reg.enab[`AST_B_TXF];
    st_next.rx_irq = st_reg.rx_full && st_reg.enab[`AST_B_RCF];
  end

  //////////////////////////////////////////////////////////////
  // state register, frozen while clk_en is low
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '{waitreq: 1'b1, tx_st: TX_IDLE, rx_st: RX_IDLE, txo: 1'b1, tx_flag: 1'b1,
                  s1: 1'b1, s2: 1'b1, s3: 1'b1, rxf: 1'b1, default: '0};
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register
  assign avs_readdata = st_reg.rdata;
  assign avs_waitrequest = st_reg.waitreq;
  assign serial_transmit_pin = st_reg.txo;
  assign tx_int_req = st_reg.tx_irq;
  assign rx_int_req = st_reg.rx_irq;

  //////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n || !clk_en);

  // a taken write to the transmit buffer while the transmitter is not idle
  sequence s_tx_write;
    wr_tx && st_reg.tx_st != TX_IDLE;
  endsequence
  // buffer freshly filled
  sequence s_tx_filled;
    s_tx_write ##1 st_reg.tx_full;
  endsequence

  chk_idle_line: assert property (!active |=> serial_transmit_pin)
    else $error("line not idle while port inactive");
  chk_start_low: assert property ($rose(st_reg.tx_st == TX_START) |-> !serial_transmit_pin)
    else $error("start bit not low");
  chk_flag_lag: assert property (s_tx_filled |-> ##1 !st_reg.tx_flag)
    else $error("empty flag not cleared in second cycle");
  chk_load_move: assert property (load_tx && !wr_tx |=> !st_reg.tx_full ##1 st_reg.tx_flag)
    else $error("buffer move did not free buffer");
  chk_lsb_first: assert property ($rose(st_reg.tx_st == TX_DATA) |-> serial_transmit_pin == st_reg.shreg[0])
    else $error("first data bit not lsb");
  chk_enable_flag: assert property ($rose(tx_en) && !st_reg.tx_full && !wr_tx |=> ##1 st_reg.tx_flag)
    else $error("enable did not set empty flag");
  chk_addr_drop: assert property (rx_done && !rx_keep && !st_reg.rx_full |=> !st_reg.rx_full)
    else $error("filtered word reached buffer");
  chk_err_clear: assert property (!st_reg.rcsc[`AST_B_CRX] |=> !st_reg.ov_err && !st_reg.fr_err)
    else $error("errors survived receive disable");
  chk_overrun: assert property (rx_done && rx_keep && st_reg.rx_full && !pop_rx |=> st_reg.ov_err)
    else $error("overrun not flagged");
  chk_bus_answer: assert property ((avs_read || avs_write) && st_reg.waitreq |=> !avs_waitrequest)
    else $error("bus answer late");
endmodule : ast_top

// ### verification/ast_station.sv
// remote serial station: drives the receive pin, captures frames on the transmit pin
// assumes the bench gives the nine-bit select and the bit length in sys_clk cycles
`timescale 1ns/1ps
module ast_station (
  input wire logic sys_clk,
  input wire logic line_in,
  output logic line_out,
  input wire logic nine_bits,
  input wire logic [7:0] bit_clks
);
  logic [9:0] cap_q[$]; // captured frames, stop level in bit 9
  logic [9:0] cap_w; // frame being captured
  int nb; // data bits of this frame
  // idle mark level; the line never floats
  initial line_out = 1'b1;
  ////////////////////////////////////////////////////////////////
  // capture at mid-bit, start low, data lsb first, one stop
  always begin
    @(negedge line_in);
    nb = nine_bits ? 9 : 8;
    cap_w = '0;
    repeat (bit_clks / 2) @(posedge sys_clk);
    // a start glitch shorter than half a bit is dropped
    if (line_in == 1'b0) begin
      for (int i = 0; i < nb; i++) begin
        repeat (bit_clks) @(posedge sys_clk);
        cap_w[i] = line_in;
      end
      repeat (bit_clks) @(posedge sys_clk);
      cap_w[9] = line_in;
      cap_q.push_back(cap_w);
    end
  end
  ////////////////////////////////////////////////////////////////
  // send one frame; a low stop level forces a framing fault
  task automatic send(input logic [8:0] d, input int n, input logic stp);
    @(posedge sys_clk);
    line_out <= 1'b0;
    repeat (bit_clks) @(posedge sys_clk);
    for (int i = 0; i < n; i++) begin
      line_out <= d[i];
      repeat (bit_clks) @(posedge sys_clk);
    end
    line_out <= stp;
    repeat (bit_clks) @(posedge sys_clk);
    line_out <= 1'b1;
    repeat (bit_clks) @(posedge sys_clk);
  endtask : send
endmodule : ast_station

// ### verification/async_serial_transceiver_bench.sv
// bench: register tasks, scenarios and verdict for the serial transceiver
// assumes ast_station on the line pins and one 100 MHz clock
`timescale 1ns/1ps
`include "ast_params.svh"
`define AST_CHK(w, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; $display("Error %s expected %h seen %h", w, e, g); end end
module async_serial_transceiver_bench;
  import ast_pkg::*;
  logic sys_clk = 1'b0; // 100 MHz
  logic resetn = 1'b0; // low for 8 cycles
  logic [2:0] avs_address = 3'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic rx_line, tx_line, tx_int_req, rx_int_req;
  logic nine = 1'b0; // station capture length
  logic [7:0] bclk = 8'h20; // 16 ticks of 2 clocks
  int mismatches = 0;
  int n_compared = 0;
  logic [9:0] fr; // captured frame
  logic [7:0] rv; // last read value
  always #5 sys_clk = ~sys_clk;
  ast_top dut_u (.sys_clk(sys_clk), .resetn(resetn), .clk_en(1'b1), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .serial_receive_pin(rx_line), .serial_transmit_pin(tx_line),
    .tx_int_req(tx_int_req), .rx_int_req(rx_int_req));
  ast_station st (.sys_clk(sys_clk), .line_in(tx_line), .line_out(rx_line), .nine_bits(nine), .bit_clks(bclk));
  ////////////////////////////////////////////////////////////////
  // one bus access, held until waitrequest is sampled low
  task automatic bus(input logic we, input logic [2:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= we;
    avs_read <= !we;
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      mismatches++;
      $display("Error waitrequest expected 0 seen 1");
    end
    rv = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input string w, input logic [2:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    `AST_CHK(w, e, rv)
  endtask : rd
  // next frame seen by the station, bounded wait
  task automatic frame(input logic [9:0] e);
    int n;
    n = 0;
    while (st.cap_q.size() == 0 && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    fr = (n < 3000) ? st.cap_q.pop_front() : 10'h3FF;
    `AST_CHK("frame", e, fr)
  endtask : frame
  ////////////////////////////////////////////////////////////////
  // software cannot clear the empty flag
  task automatic t_reset;
    rd("flags", `AST_IX_FLAGS, 8'h10);
    wr(`AST_IX_FLAGS, 8'h00);
    rd("flags", `AST_IX_FLAGS, 8'h10);
  endtask : t_reset
  // buffer loaded with tx disabled waits for the enable
  task automatic t_enable;
    wr(`AST_IX_DIV, 8'h01);
    wr(`AST_IX_ENAB, 8'h30);
    wr(`AST_IX_PRIO, 8'h30);
    wr(`AST_IX_RCSC, 8'h90);
    wr(`AST_IX_TXSC, 8'h04);
    wr(`AST_IX_TXBUF, 8'hC3);
    rd("flags", `AST_IX_FLAGS, 8'h00);
    repeat (100) @(posedge sys_clk);
    `AST_CHK("txpin", 1'b1, tx_line)
    wr(`AST_IX_TXSC, 8'h24);
    // the move happens one edge after the enable; the flag follows one edge later
    @(posedge sys_clk);
    rd("flags", `AST_IX_FLAGS, 8'h10);
    rd("txsc", `AST_IX_TXSC, 8'h24);
    frame(10'h2C3);
    `AST_CHK("txirq", 1'b1, tx_int_req)
  endtask : t_enable
  // second byte waits in the buffer until the stop bit is out
  task automatic t_b2b;
    // let the previous stop bit finish so the first byte loads at once
    repeat (bclk) @(posedge sys_clk);
    wr(`AST_IX_TXBUF, 8'hA5);
    wr(`AST_IX_TXBUF, 8'h5A);
    rd("flags", `AST_IX_FLAGS, 8'h00);
    `AST_CHK("txirq", 1'b0, tx_int_req)
    frame(10'h2A5);
    frame(10'h25A);
    repeat (bclk) @(posedge sys_clk);
    rd("txsc", `AST_IX_TXSC, 8'h26);
  endtask : t_b2b
  // ninth bit follows the stored bit, not the data parity
  task automatic t_tx9;
    nine <= 1'b1;
    wr(`AST_IX_TXSC, 8'h65);
    wr(`AST_IX_TXBUF, 8'h3C);
    frame(10'h33C);
    wr(`AST_IX_TXSC, 8'h64);
    wr(`AST_IX_TXBUF, 8'hC3);
    frame(10'h2C3);
    nine <= 1'b0;
    wr(`AST_IX_TXSC, 8'h24);
  endtask : t_tx9
  // low speed with divisor 0: 64 clocks per bit
  task automatic t_slow;
    wr(`AST_IX_DIV, 8'h00);
    wr(`AST_IX_TXSC, 8'h20);
    bclk <= 8'h40;
    wr(`AST_IX_TXBUF, 8'h96);
    frame(10'h296);
    bclk <= 8'h20;
    wr(`AST_IX_DIV, 8'h01);
    wr(`AST_IX_TXSC, 8'h24);
  endtask : t_slow
  // receive while transmitting
  task automatic t_rx;
    fork
      st.send(9'h05A, 8, 1'b1);
      wr(`AST_IX_TXBUF, 8'h81);
    join
    frame(10'h281);
    rd("flags", `AST_IX_FLAGS, 8'h30);
    `AST_CHK("rxirq", 1'b1, rx_int_req)
    rd("rxsc", `AST_IX_RCSC, 8'h90);
    rd("rxbuf", `AST_IX_RXBUF, 8'h5A);
    rd("flags", `AST_IX_FLAGS, 8'h10);
  endtask : t_rx
  // overrun, clear by enable, disabled receiver, framing fault
  task automatic t_err;
    st.send(9'h011, 8, 1'b1);
    st.send(9'h022, 8, 1'b1);
    rd("rxsc", `AST_IX_RCSC, 8'h92);
    rd("rxbuf", `AST_IX_RXBUF, 8'h11);
    wr(`AST_IX_RCSC, 8'h80);
    rd("rxsc", `AST_IX_RCSC, 8'h80);
    st.send(9'h044, 8, 1'b1);
    rd("flags", `AST_IX_FLAGS, 8'h10);
    wr(`AST_IX_RCSC, 8'h90);
    st.send(9'h033, 8, 1'b0);
    bus(1'b0, `AST_IX_RCSC, 8'h00);
    `AST_CHK("framing_error_flag", 1'b1, rv[`AST_B_FE])
    // the low stop may look like a new start; let it finish
    repeat (12 * bclk) @(posedge sys_clk);
    bus(1'b0, `AST_IX_RXBUF, 8'h00);
    wr(`AST_IX_RCSC, 8'h80);
    wr(`AST_IX_RCSC, 8'h90);
  endtask : t_err
  // address filter keeps only ninth-bit-one words
  task automatic t_addr;
    wr(`AST_IX_RCSC, 8'hD8);
    st.send(9'h0AB, 9, 1'b1);
    rd("flags", `AST_IX_FLAGS, 8'h10);
    st.send(9'h1CD, 9, 1'b1);
    rd("rxsc", `AST_IX_RCSC, 8'hD9);
    rd("rxbuf", `AST_IX_RXBUF, 8'hCD);
    wr(`AST_IX_RCSC, 8'hD0);
    st.send(9'h0EE, 9, 1'b1);
    rd("rxbuf", `AST_IX_RXBUF, 8'hEE);
    wr(`AST_IX_RCSC, 8'h90);
  endtask : t_addr
  // sync select set keeps the line idle; the buffer is kept
  task automatic t_sync;
    int n;
    n = 0;
    wr(`AST_IX_TXSC, 8'h34);
    wr(`AST_IX_TXBUF, 8'h77);
    repeat (400) begin
      @(posedge sys_clk);
      if (tx_line !== 1'b1) n++;
    end
    `AST_CHK("idle", 0, n)
    wr(`AST_IX_TXSC, 8'h24);
    frame(10'h277);
  endtask : t_sync
  ////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic results;
    if (mismatches == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results
  // main sequence
  initial begin
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_reset;
    t_enable;
    t_b2b;
    t_tx9;
    t_slow;
    t_rx;
    t_err;
    t_addr;
    t_sync;
    results;
  end
  // watchdog, several times the expected run
  initial begin
    repeat (40000) @(posedge sys_clk);
    mismatches++;
    results;
  end
endmodule : async_serial_transceiver_bench
